// File: dot_clock_pkg.sv
package dot_clock_pkg;

    // Register port
    localparam int           ADDR_W        = 8;
    localparam int           DATA_W        = 8;
    localparam logic [7:0]   REG_IN_SEL    = 8'h00;
    localparam logic [7:0]   REG_OUT_SEL   = 8'h01;
    localparam logic [7:0]   REG_STATUS    = 8'h02;

    // Reset values
    localparam logic [7:0]   IN_SEL_RESET  = 8'h00;
    localparam logic [7:0]   OUT_SEL_RESET = 8'h3e;

    // Input-select fields
    localparam int           IN_CODE_LSB   = 0;
    localparam int           IN_CODE_W     = 3;
    localparam int           IN_DOUBLE_BIT = 4;
    localparam logic [2:0]   CODE_A        = 3'h0;
    localparam logic [2:0]   CODE_B        = 3'h1;
    localparam logic [2:0]   CODE_SINGLE0  = 3'h2;
    localparam logic [2:0]   CODE_SINGLE1  = 3'h3;
    localparam logic [2:0]   CODE_DIFF     = 3'h4;

    // Output-select fields
    localparam int           OUT_REF_LSB   = 0;
    localparam int           OUT_VID_LSB   = 3;
    localparam int           RATIO_W       = 3;
    localparam int           OUT_SHIFT_BIT = 6;
    localparam logic [2:0]   RATIO_HELD    = 3'h7;
    localparam logic [5:0]   COUNTER_CLEAR = 6'h3f;

    // Common counter
    localparam int           CNT_W         = 6;

    // Settling window after a select write
    localparam int           CLK_PERIOD_NS = 100;
    localparam int           SETTLE_NS     = 30;
    localparam int           SETTLE_RAW    =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int           SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
    localparam int           SETTLE_W      = 4;

    typedef enum logic [3:0] {
        SRC_A      = 4'b0001,
        SRC_B      = 4'b0010,
        SRC_SINGLE = 4'b0100,
        SRC_DIFF   = 4'b1000
    } source_e;

endpackage : dot_clock_pkg

// File: clock_ratio_tap.sv
`timescale 1ns/10ps
module clock_ratio_tap #(
    parameter int CNT_W = 6
) (
    input  wire logic [CNT_W-1:0] cnt,      // Common counter value
    input  wire logic             dotLevel, // Registered pixel clock level
    input  wire logic [2:0]       ratio,    // Power-of-two ratio code
    input  wire logic             heldLevel,// Level while held
    output logic                  tapLevel  // Divided clock level
);
    logic [2:0] bitSel;

    always_comb begin
        bitSel = ratio - 3'h1;
        if (ratio == 3'h7) begin
            tapLevel = heldLevel;
        end else if (ratio == 3'h0) begin
            tapLevel = dotLevel;
        end else begin
            tapLevel = cnt[bitSel];
        end
    end

endmodule : clock_ratio_tap

// File: dot_clock_source_and_divider.sv
`timescale 1ns/10ps
module dot_clock_source_and_divider
    import dot_clock_pkg::*;
#(
    parameter int CNT_WIDTH = dot_clock_pkg::CNT_W
) (
    input  wire logic                            clk,        // 10 MHz clock
    input  wire logic                            reset,      // Async reset
    input  wire logic [dot_clock_pkg::ADDR_W-1:0] regAddr,    // Reg address
    input  wire logic [dot_clock_pkg::DATA_W-1:0] regWrData,  // Write data
    input  wire logic                            regWrite,   // Write strobe
    input  wire logic                            regRead,    // Read strobe
    output logic      [dot_clock_pkg::DATA_W-1:0] regRdData,  // Read data
    input  wire logic                            clockInputA,// Clock pin a
    input  wire logic                            clockInputB,// Clock pin b
    input  wire logic                            dualClockP, // Dual pin true
    input  wire logic                            dualClockN, // Dual pin compl.
    input  wire logic                            blankActive,// Blanking level
    output logic                                 refClockOut,// Reference clock
    output logic                                 shiftClockOut,// Shift clock
    output logic                                 videoClockOut // Video clock
);
    import dot_clock_pkg::*;

    function automatic logic codeValid(input logic [7:0] v);
        logic [2:0] c;
        c = v[IN_CODE_LSB +: IN_CODE_W];
        codeValid = (c <= CODE_DIFF);
    endfunction : codeValid

    function automatic source_e codeSource(input logic [7:0] v);
        logic [2:0] c;
        c = v[IN_CODE_LSB +: IN_CODE_W];
        unique case (c)
            CODE_A:                     codeSource = SRC_A;
            CODE_B:                     codeSource = SRC_B;
            CODE_SINGLE0, CODE_SINGLE1: codeSource = SRC_SINGLE;
            default:                    codeSource = SRC_DIFF;
        endcase
    endfunction : codeSource

    // Register state
    logic [7:0]          inSel_r,   inSel_nxt;
    logic [7:0]          outSel_r,  outSel_nxt;
    logic [7:0]          actSel_r,  actSel_nxt;
    logic [SETTLE_W-1:0] settle_r,  settle_nxt;
    logic [7:0]          rdData_r,  rdData_nxt;

    // Pin and counter state
    logic [4:0]          sync1_r,   sync2_r;
    logic                srcPrev_r, srcPrev_nxt;
    logic                pixLvl_r,  pixLvl_nxt;
    logic [CNT_WIDTH-1:0] cnt_r,    cnt_nxt;

    // Output state
    logic                refClk_r,  refClk_nxt;
    logic                shiftClk_r, shiftClk_nxt;
    logic                vidClk_r,  vidClk_nxt;
    logic                gateOpen_r, gateOpen_nxt;

    logic                wrIn;
    logic                wrOut;
    logic                counterClear;
    logic                dotRise;
    logic                wrap;
    logic                srcLevel;
    logic                pixelRateClock;
    logic                doubled;
    logic                blankSync;
    logic                refTap;
    logic                vidTap;
    source_e             srcSel;

    assign wrIn         = regWrite && (regAddr == REG_IN_SEL);
    assign wrOut        = regWrite && (regAddr == REG_OUT_SEL);
    assign counterClear = wrOut && (regWrData[5:0] == COUNTER_CLEAR);
    assign srcSel       = codeSource(inSel_r);
    assign doubled      = inSel_r[IN_DOUBLE_BIT];
    assign blankSync    = sync2_r[4];

    always_comb begin
        inSel_nxt  = inSel_r;
        outSel_nxt = outSel_r;
        actSel_nxt = actSel_r;
        settle_nxt = settle_r;
        rdData_nxt = 8'h00;
        if (settle_r != '0) begin
            settle_nxt = settle_r - SETTLE_W'(1);
        end
        if (wrIn && codeValid(regWrData)) begin
            inSel_nxt  = regWrData;
            settle_nxt = SETTLE_W'(SETTLE_CYCLES);
        end
        if (wrOut) begin
            outSel_nxt = regWrData;
            settle_nxt = SETTLE_W'(SETTLE_CYCLES);
        end
        if (counterClear) begin
            actSel_nxt = regWrData;
        end else if (wrap) begin
            actSel_nxt = outSel_r;
        end
        if (regRead) begin
            unique case (regAddr)
                REG_IN_SEL:  rdData_nxt = inSel_r;
                REG_OUT_SEL: rdData_nxt = outSel_r;
                REG_STATUS:  rdData_nxt = {settle_r != '0, gateOpen_r,
                                           actSel_r != outSel_r, doubled,
                                           srcSel};
                default:     rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inSel_r  <= IN_SEL_RESET;
            outSel_r <= OUT_SEL_RESET;
            actSel_r <= OUT_SEL_RESET;
            settle_r <= '0;
            rdData_r <= 8'h00;
        end else begin
            inSel_r  <= inSel_nxt;
            outSel_r <= outSel_nxt;
            actSel_r <= actSel_nxt;
            settle_r <= settle_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    // Pixel clock source: sampled pins, selection and optional doubler
    always_comb begin
        srcLevel = 1'b0;
        unique case (srcSel)
            SRC_A:      srcLevel = sync2_r[0];
            SRC_B:      srcLevel = sync2_r[1];
            SRC_SINGLE: srcLevel = sync2_r[2];
            SRC_DIFF:   srcLevel = sync2_r[2] & ~sync2_r[3];
        endcase
        // Doubling: one pixel pulse per source edge
        pixelRateClock = doubled ? (srcLevel ^ srcPrev_r) : srcLevel;
        srcPrev_nxt    = srcLevel;
        pixLvl_nxt     = pixelRateClock;
        dotRise        = pixelRateClock & ~pixLvl_r;
        wrap           = dotRise && (cnt_r == '1);
        cnt_nxt        = cnt_r;
        if (counterClear) begin
            cnt_nxt = '0;
        end else if (dotRise) begin
            cnt_nxt = cnt_r + CNT_WIDTH'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_r   <= 5'h00;
            sync2_r   <= 5'h00;
            srcPrev_r <= 1'b0;
            pixLvl_r  <= 1'b0;
            cnt_r     <= '0;
        end else begin
            sync1_r   <= {blankActive, dualClockN, dualClockP,
                          clockInputB, clockInputA};
            sync2_r   <= sync1_r;
            srcPrev_r <= srcPrev_nxt;
            pixLvl_r  <= pixLvl_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    // Divided outputs, bit 7 never consulted

    clock_ratio_tap #(
        .CNT_W     (CNT_WIDTH)
    ) refTapInst (
        .cnt       (cnt_r),
        .dotLevel  (pixLvl_r),
        .ratio     (actSel_r[OUT_REF_LSB +: RATIO_W]),
        .heldLevel (1'b0),
        .tapLevel  (refTap)
    );

    clock_ratio_tap #(
        .CNT_W     (CNT_WIDTH)
    ) vidTapInst (
        .cnt       (cnt_r),
        .dotLevel  (pixLvl_r),
        .ratio     (actSel_r[OUT_VID_LSB +: RATIO_W]),
        .heldLevel (1'b1),
        .tapLevel  (vidTap)
    );

    always_comb begin
        gateOpen_nxt = gateOpen_r;
        // Gate moves only while the reference is low: no clipped pulse
        if (!refTap) begin
            gateOpen_nxt = !blankSync;
        end
        refClk_nxt   = refTap;
        shiftClk_nxt = refTap && gateOpen_r
                       && actSel_r[OUT_SHIFT_BIT];
        vidClk_nxt   = vidTap;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gateOpen_r <= 1'b0;
            refClk_r   <= 1'b0;
            shiftClk_r <= 1'b0;
            vidClk_r   <= 1'b1;
        end else begin
            gateOpen_r <= gateOpen_nxt;
            refClk_r   <= refClk_nxt;
            shiftClk_r <= shiftClk_nxt;
            vidClk_r   <= vidClk_nxt;
        end
    end

    assign refClockOut   = refClk_r;
    assign shiftClockOut = shiftClk_r;
    assign videoClockOut = vidClk_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence clearWrite;
        counterClear;
    endsequence

    sequence clearedOutputs;
        (cnt_r == '0) ##1 (!refClockOut && !shiftClockOut && videoClockOut);
    endsequence

    a_counter_clear: assert property (
        clearWrite |=> clearedOutputs)
        else $error("3f write did not clear counter and outputs");

    a_source_a_direct: assert property (
        wrIn && regWrData[2:0] == CODE_A && !regWrData[4]
        |=> srcSel == SRC_A && !doubled)
        else $error("code 00 did not select input a direct");

    a_source_dual: assert property (
        wrIn && regWrData[2:0] == CODE_DIFF
        |=> srcSel == SRC_DIFF)
        else $error("code 04 did not select differential input");

    a_doubler_sel: assert property (
        wrIn && codeValid(regWrData) |=> doubled == $past(regWrData[4]))
        else $error("doubler select not taken from bit 4");

    a_invalid_keep: assert property (
        wrIn && !codeValid(regWrData) |=> $stable(inSel_r))
        else $error("unlisted input code changed the source");

    a_video_held: assert property (
        actSel_r[5:3] == RATIO_HELD && $stable(actSel_r)
        |=> videoClockOut)
        else $error("video clock not held high");

    a_ref_held: assert property (
        actSel_r[2:0] == RATIO_HELD && !actSel_r[6]
        |=> !refClockOut && !shiftClockOut)
        else $error("reference or shift clock not held low");

    a_shift_disabled: assert property (
        !actSel_r[OUT_SHIFT_BIT] |=> !shiftClockOut)
        else $error("shift clock ran while disabled");

    a_shift_in_ref: assert property (
        shiftClockOut |-> refClockOut)
        else $error("shift clock high while reference low");

    a_blank_holds: assert property (
        blankSync && !refTap ##1 blankSync |=> !shiftClockOut)
        else $error("shift clock restarted during blanking");

    a_phase_lock: assert property (
        actSel_r[5:3] == actSel_r[2:0] && actSel_r[2:0] != RATIO_HELD
        && $stable(actSel_r) |=> refClockOut == videoClockOut)
        else $error("reference and video clocks out of phase");

    a_ratio_at_wrap: assert property (
        actSel_r != $past(actSel_r) |-> $past(wrap || counterClear))
        else $error("ratio changed away from counter wrap");

    a_div_two: assert property (
        actSel_r[5:3] == 3'h1 && $stable(actSel_r) && dotRise
        && !counterClear
        |=> ##1 videoClockOut != $past(videoClockOut))
        else $error("divide by two video clock did not toggle");

    a_source_b_direct: assert property (
        wrIn && regWrData[2:0] == CODE_B
        |=> srcSel == SRC_B)
        else $error("code 01 did not select input b");

    a_source_single: assert property (
        wrIn && (regWrData[2:0] == CODE_SINGLE0
                 || regWrData[2:0] == CODE_SINGLE1)
        |=> srcSel == SRC_SINGLE)
        else $error("codes 02 and 03 did not select single-ended input");

    a_video_div_one: assert property (
        actSel_r[5:3] == 3'h0 |=> videoClockOut == $past(pixLvl_r))
        else $error("divide by one video clock not the pixel level");

    a_ref_div_one: assert property (
        actSel_r[2:0] == 3'h0 |=> refClockOut == $past(pixLvl_r))
        else $error("divide by one reference clock not the pixel level");

    a_shift_follows: assert property (
        actSel_r[OUT_SHIFT_BIT] && gateOpen_r
        |=> shiftClockOut == refClockOut)
        else $error("open shift clock differs from reference clock");

    a_counter_step: assert property (
        !counterClear && dotRise
        |=> cnt_r == $past(cnt_r) + CNT_WIDTH'(1))
        else $error("counter did not advance on pixel rise");

    a_counter_hold: assert property (
        !counterClear && !dotRise |=> $stable(cnt_r))
        else $error("counter moved without a pixel rise");

endmodule : dot_clock_source_and_divider

// File: clock_source_model.sv
`timescale 1ns/10ps
module clock_source_model #(
    parameter int HALF_A = 2,
    parameter int HALF_B = 3,
    parameter int HALF_D = 4
) (
    input  wire logic clk,         // Bench clock
    output logic      clockInputA, // Oscillator on input a
    output logic      clockInputB, // Oscillator on input b
    output logic      dualClockP,  // Dual input true side
    output logic      dualClockN   // Dual input complement side
);
    // Oscillators run free, reset or not, as real crystals do
    int   cntA = 0;
    int   cntB = 0;
    int   cntD = 0;
    logic lvlA = 1'b0;
    logic lvlB = 1'b0;
    logic lvlP = 1'b0;
    logic lvlN = 1'b1;

    assign clockInputA = lvlA;
    assign clockInputB = lvlB;
    assign dualClockP  = lvlP;
    assign dualClockN  = lvlN;

    always @(posedge clk) begin
        cntA <= (cntA == HALF_A - 1) ? 0 : cntA + 1;
        cntB <= (cntB == HALF_B - 1) ? 0 : cntB + 1;
        cntD <= (cntD == HALF_D - 1) ? 0 : cntD + 1;
        if (cntA == HALF_A - 1) lvlA <= ~lvlA;
        if (cntB == HALF_B - 1) lvlB <= ~lvlB;
        if (cntD == HALF_D - 1) begin
            lvlP <= ~lvlP;
            lvlN <= lvlP;
        end
    end
endmodule : clock_source_model

// File: dot_clock_source_and_divider_bench.sv
`timescale 1ns/10ps
module dot_clock_source_and_divider_bench;
    import dot_clock_pkg::*;

    localparam logic [7:0] CODES [12] = '{8'h00, 8'h01, 8'h02, 8'h03,
        8'h04, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'he9, 8'h9c};

    logic              clk;
    logic              reset;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWrite;
    logic              regRead;
    logic [DATA_W-1:0] regRdData;
    logic              clockInputA, clockInputB, dualClockP, dualClockN;
    logic              blankActive, refClockOut, shiftClockOut;
    logic              videoClockOut;
    logic              sPrev = 1'b0;
    int                failCount = 0;
    int                checks = 0;

    dot_clock_source_and_divider u_dut (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .clockInputA(clockInputA),
        .clockInputB(clockInputB), .dualClockP(dualClockP),
        .dualClockN(dualClockN), .blankActive(blankActive),
        .refClockOut(refClockOut), .shiftClockOut(shiftClockOut),
        .videoClockOut(videoClockOut)
    );

    clock_source_model u_src (
        .clk(clk), .clockInputA(clockInputA), .clockInputB(clockInputB),
        .dualClockP(dualClockP), .dualClockN(dualClockN)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    function automatic logic pick(input int sel);
        return (sel == 0) ? refClockOut :
               (sel == 1) ? shiftClockOut : videoClockOut;
    endfunction : pick

    // Cycles between two rising edges; all ones when the output rose fewer than twice in 2000 cycles
    task automatic period(input int sel, output logic [15:0] per);
        int   t0, t1, n;
        logic p, c;
        t0 = -1;
        t1 = -1;
        p  = pick(sel);
        for (n = 0; n < 2000 && t1 < 0; n++) begin
            @(posedge clk);
            #1 c = pick(sel);
            if (c && !p) begin
                if (t0 < 0) t0 = n;
                else t1 = n;
            end
            p = c;
        end
        per = (t1 < 0) ? 16'hffff : 16'(t1 - t0);
    endtask : period

    // Clear the counter, queue a ratio and wait past the next wrap
    task automatic setOut(input logic [7:0] v);
        logic [7:0] d;
        wr(REG_OUT_SEL, 8'h3f);
        wr(REG_OUT_SEL, v);
        rd(REG_STATUS, d);
        check("pending", 16'h1, 16'(d[5]));
        repeat (600) @(posedge clk);
        rd(REG_STATUS, d);
        check("pending", 16'h0, 16'(d[5]));
    endtask : setOut

    task automatic results;
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // A shift pulse is never high without reference, nor cut short
    always @(posedge clk) begin
        if (!reset) begin
            check("shiftPulse", 16'h0, 16'((shiftClockOut && !refClockOut)
                || (sPrev && !shiftClockOut && refClockOut)));
        end
        sPrev <= shiftClockOut;
    end

    initial begin
        #6_000_000;
        failCount++;
        results();
    end

    initial begin
        logic [7:0]  d;
        logic [15:0] per;
        logic [15:0] expPer;
        logic [4:0]  expSt;
        reset       = 1'b1;
        regAddr     = '0;
        regWrData   = '0;
        regWrite    = 1'b0;
        regRead     = 1'b0;
        blankActive = 1'b0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(REG_IN_SEL, d);
        check("inSel", 16'h00, 16'(d));
        rd(REG_OUT_SEL, d);
        check("outSel", 16'h3e, 16'(d));
        rd(REG_STATUS, d);
        check("source", 16'h01, 16'(d[4:0]));
        check("video", 16'h1, 16'(videoClockOut));
        period(0, per);
        check("refPeriod", 16'd256, per);
        check("shift", 16'h0, 16'(shiftClockOut));
        wr(8'h05, 8'hff);
        rd(8'h05, d);
        check("unmapped", 16'h00, 16'(d));
        rd(REG_IN_SEL, d);
        check("inSel", 16'h00, 16'(d));
        setOut(8'h00);
        for (int k = 0; k < 12; k++) begin
            wr(REG_IN_SEL, CODES[k]);
            repeat (8) @(posedge clk);
            expPer = (CODES[k][2:0] == 3'h0) ? 16'd4 :
                     (CODES[k][2:0] == 3'h1) ? 16'd6 : 16'd8;
            if (CODES[k][4]) expPer = expPer >> 1;
            expSt = {CODES[k][4], (CODES[k][2:0] == 3'h0) ? 4'h1 :
                     (CODES[k][2:0] == 3'h1) ? 4'h2 :
                     (CODES[k][2:0] == 3'h4) ? 4'h8 : 4'h4};
            rd(REG_STATUS, d);
            check("source", 16'(expSt), 16'(d[4:0]));
            period(0, per);
            check("refPeriod", expPer, per);
            period(2, per);
            check("videoPeriod", expPer, per);
        end
        wr(REG_IN_SEL, 8'h01);
        wr(REG_IN_SEL, 8'h05);
        rd(REG_IN_SEL, d);
        check("inSel", 16'h01, 16'(d));
        rd(REG_STATUS, d);
        check("source", 16'h02, 16'(d[4:0]));
        wr(REG_IN_SEL, 8'h00);
        for (int k = 0; k < 7; k++) begin
            setOut(8'((k % 2) * 128 + (6 - k) * 8 + k));
            period(0, per);
            check("refPeriod", 16'(4 << k), per);
            period(2, per);
            check("videoPeriod", 16'(4 << (6 - k)), per);
        end
        setOut(8'h07);
        period(0, per);
        check("refHeld", 16'hffff, per);
        check("shift", 16'h0, 16'(shiftClockOut));
        period(2, per);
        check("videoPeriod", 16'd4, per);
        setOut(8'h38);
        period(2, per);
        check("videoHeld", 16'hffff, per);
        check("video", 16'h1, 16'(videoClockOut));
        period(0, per);
        check("refPeriod", 16'd4, per);
        setOut(8'h79);
        period(1, per);
        check("shiftPeriod", 16'd8, per);
        @(posedge clk) blankActive <= 1'b1;
        repeat (10) @(posedge clk);
        period(0, per);
        check("refPeriod", 16'd8, per);
        period(1, per);
        check("shiftBlank", 16'hffff, per);
        @(posedge clk) blankActive <= 1'b0;
        period(1, per);
        check("shiftPeriod", 16'd8, per);
        wr(REG_OUT_SEL, 8'h7f);
        repeat (2) @(posedge clk);
        #1 check("ref", 16'h0, 16'(refClockOut));
        check("shift", 16'h0, 16'(shiftClockOut));
        check("video", 16'h1, 16'(videoClockOut));
        results();
    end
endmodule : dot_clock_source_and_divider_bench
